/* common/led_ctrl_defines.svh */
// timing counts, widths and reset values for the enable and mode control
`ifndef LED_CTRL_DEFINES_SVH
`define LED_CTRL_DEFINES_SVH

`define CLK_HZ 25000000
`define CLK_PERIOD_NS 40

`define T_SHDN_NS 2500000
`define T_DELAY_NS 100000
`define T_DET_LOW_NS 260000
`define T_WIN_NS 1000000
`define T_STEP_NS 213000
`define T_HALF_NS 5000000
`define SW_FREQ_HZ 600000

// least times round up, longest times round down
`define SHDN_CYC ((`T_SHDN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_CYC ((`T_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DET_LOW_CYC ((`T_DET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIN_CYC (`T_WIN_NS / `CLK_PERIOD_NS)
`define STEP_CYC (`T_STEP_NS / `CLK_PERIOD_NS)
`define HALF_CYC (`T_HALF_NS / `CLK_PERIOD_NS)
`define SW_DIV (`CLK_HZ / `SW_FREQ_HZ)

`define CNT_W 17
`define STEP_W 5
`define RAMP_W 6
`define SW_DIV_W 6
`define OL_W 4

`define RAMP_STEPS 6'h20
`define OL_CYCLES 4'h8
`define FULL_STEP 5'h1F

`endif

/* common/led_ctrl_pkg.sv */
// types shared by the enable and mode control
`include "led_ctrl_defines.svh"

package led_ctrl_pkg;

   typedef logic [`CNT_W-1:0] cnt_t;
   typedef logic [`STEP_W-1:0] step_t;
   typedef logic [`RAMP_W-1:0] ramp_t;

   typedef enum logic [2:0] {
      ST_OFF    = 3'h1,
      ST_DETECT = 3'h2,
      ST_RUN    = 3'h4
   } ctl_state_e;

endpackage : led_ctrl_pkg

/* dv/ctrl_host_model.sv */
// host model driving the control pin
`timescale 1ns/1ps
module ctrl_host_model (
   input wire logic i_ref_clk,
   output logic o_ctrl_pin
);
   initial o_ctrl_pin = 1'b0;
   // level held n cycles, changed just after the edge
   task automatic drive(input logic level, input int n);
      @(posedge i_ref_clk);
      #1 o_ctrl_pin = level;
      repeat (n) @(posedge i_ref_clk);
   endtask : drive
   // enable, wait past the delay, then a qualifying low inside the window
   task automatic ask_one_wire(input int low_cyc);
      drive(1'b1, 2520);
      drive(1'b0, low_cyc);
      drive(1'b1, 0);
   endtask : ask_one_wire
endmodule : ctrl_host_model

/* dv/led_ctrl_checker_assertions.sv */
// port checks for the enable and mode control
`timescale 1ns/1ps
`include "led_ctrl_defines.svh"
module led_ctrl_checker
   import led_ctrl_pkg::*;
#(parameter cnt_t HALF_CYC = 17'h1E848) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic o_enabled,
   input wire logic o_switch_en,
   input wire logic o_detect_active,
   input wire logic o_mode_valid,
   input wire logic o_one_wire_mode,
   input wire logic [`RAMP_W-1:0] o_ramp_level,
   input wire logic o_half_ilim,
   input wire logic o_ref_chop,
   input wire logic o_sw_tick,
   input wire logic o_open_led_fault
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   // cycles since enable, saturating
   cnt_t on_cnt;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         on_cnt <= '0;
      end else begin
         on_cnt <= !o_enabled ? '0 : (on_cnt == '1 ? on_cnt : on_cnt + 1'b1);
      end
   end
   a_switch_off_shdn: assert property (o_switch_en == o_enabled && (o_enabled || !(o_ref_chop || o_half_ilim)))
      else $error("switch active in shutdown");
   a_enable_opens_window: assert property ($rose(o_enabled) |-> o_detect_active && !o_mode_valid)
      else $error("window not opened at enable");
   a_mode_held: assert property (o_mode_valid && $past(o_mode_valid) |-> $stable(o_one_wire_mode))
      else $error("mode changed while running");
   a_ramp_one_step: assert property (o_enabled && $past(o_enabled) && $changed(o_ramp_level) |-> o_ramp_level == $past(o_ramp_level) + 6'h01)
      else $error("ramp jumped");
   a_half_limit_on: assert property (on_cnt > 17'h00001 && on_cnt < HALF_CYC |-> o_half_ilim)
      else $error("half limit missing");
   a_half_limit_off: assert property (on_cnt > HALF_CYC + 17'h00002 |-> !o_half_ilim)
      else $error("half limit too long");
   a_tick_period: assert property (o_sw_tick |=> !o_sw_tick [*8])
      else $error("switching tick too fast");
   a_fault_shuts_down: assert property ($rose(o_open_led_fault) |-> !o_enabled && !o_switch_en)
      else $error("fault without shutdown");
   c_one_wire: cover property ($rose(o_one_wire_mode));
   c_fault: cover property ($rose(o_open_led_fault));
   c_pwm_run: cover property ($rose(o_mode_valid) && !o_one_wire_mode);
endmodule : led_ctrl_checker

bind led_driver_enable_mode_control led_ctrl_checker #(.HALF_CYC(HALF_CYC)) led_ctrl_checker_i (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .o_enabled(o_enabled), .o_switch_en(o_switch_en),
   .o_detect_active(o_detect_active), .o_mode_valid(o_mode_valid), .o_one_wire_mode(o_one_wire_mode),
   .o_ramp_level(o_ramp_level), .o_half_ilim(o_half_ilim), .o_ref_chop(o_ref_chop), .o_sw_tick(o_sw_tick),
   .o_open_led_fault(o_open_led_fault));

/* dv/test_led_driver_enable_mode_control.sv */
// self-checking bench for the enable and mode control
`timescale 1ns/1ps
module test_led_driver_enable_mode_control
   import led_ctrl_pkg::*;
;
   localparam cnt_t SHDN = 17'h000C8;
   localparam cnt_t DLOW = 17'h00028;
   localparam cnt_t WIN = 17'h00A28;
   localparam cnt_t STEP = 17'h0000A;
   localparam cnt_t HALF = 17'h0012C;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic ovp = 1'b0;
   logic fb_low = 1'b0;
   logic load = 1'b0;
   logic [4:0] code = 5'h00;
   wire logic ctrl;
   logic enabled, sw_en, detect, mode_valid, one_wire, done, half, chop, tick, fault;
   logic [5:0] ramp;
   logic [4:0] ref_code;
   int n_tests = 0;
   int n_mismatch = 0;
   int n_cycles = 0;
   always #20 i_ref_clk = ~i_ref_clk;
   ctrl_host_model ctrl_host_model_i (.i_ref_clk(i_ref_clk), .o_ctrl_pin(ctrl));
   led_driver_enable_mode_control #(.SHDN_CYC(SHDN), .DET_LOW_CYC(DLOW), .WIN_CYC(WIN), .STEP_CYC(STEP),
      .HALF_CYC(HALF)) led_driver_enable_mode_control_i (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ctrl_pin(ctrl), .i_switch_node_ovp(ovp),
      .i_feedback_node_low(fb_low), .i_bright_load(load), .i_bright_code(code), .o_enabled(enabled),
      .o_switch_en(sw_en), .o_detect_active(detect), .o_mode_valid(mode_valid), .o_one_wire_mode(one_wire),
      .o_ramp_level(ramp), .o_ramp_done(done), .o_half_ilim(half), .o_ref_code(ref_code), .o_ref_chop(chop),
      .o_sw_tick(tick), .o_open_led_fault(fault));
   task automatic chk(input string what, input logic [5:0] seen, input logic [5:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : cyc
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   task automatic t_power_reset(input int n);
      i_rst_b = 1'b0;
      cyc(n);
      i_rst_b = 1'b1;
      cyc(2);
      chk("ref_code", ref_code, 6'h1F);
      chk("enabled", enabled, 1'b0);
      $display("power reset done");
   endtask : t_power_reset
   task automatic t_pwm;
      ctrl_host_model_i.drive(1'b1, 0);
      cyc(6);
      chk("enable", {enabled, detect, half}, 6'h07);
      cyc(int'(STEP) * 16);
      chk("ramp", ramp, 6'h10);
      cyc(int'(STEP) * 16 + 20);
      chk("ramp", {done, ramp[4:0]}, 6'h20);
      chk("half", half, 1'b0);
      cyc(int'(WIN));
      chk("mode", {mode_valid, one_wire}, 6'h02);
      ctrl_host_model_i.drive(1'b0, 8);
      cyc(1);
      chk("chop", chop, 1'b0);
      ctrl_host_model_i.drive(1'b1, 4);
      cyc(1);
      chk("chop", {chop, one_wire}, 6'h02);
      $display("pwm start done");
   endtask : t_pwm
   task automatic t_shutdown;
      ctrl_host_model_i.drive(1'b0, int'(SHDN) - 10);
      cyc(1);
      chk("enabled", enabled, 1'b1);
      cyc(20);
      chk("off", {enabled, sw_en, detect, mode_valid}, 6'h00);
      $display("shutdown done");
   endtask : t_shutdown
   task automatic t_one_wire;
      ctrl_host_model_i.ask_one_wire(45);
      cyc(4);
      chk("mode", {mode_valid, one_wire, detect, chop}, 6'h0D);
      code = 5'h05;
      load = 1'b1;
      cyc(1);
      load = 1'b0;
      cyc(2);
      chk("ref_code", ref_code, 6'h05);
      ctrl_host_model_i.drive(1'b0, 50);
      ctrl_host_model_i.drive(1'b1, 5);
      cyc(1);
      chk("mode", {mode_valid, one_wire}, 6'h03);
      $display("one-wire start done");
   endtask : t_one_wire
   task automatic t_fault;
      ctrl_host_model_i.drive(1'b1, 6);
      cyc(1);
      ovp = 1'b1;
      cyc(400);
      chk("fault", fault, 1'b0);
      fb_low = 1'b1;
      cyc(9 * 41 + 4);
      chk("fault", {fault, enabled, sw_en}, 6'h04);
      ovp = 1'b0;
      fb_low = 1'b0;
      cyc(20);
      chk("enabled", enabled, 1'b0);
      ctrl_host_model_i.drive(1'b0, 5);
      ctrl_host_model_i.drive(1'b1, 6);
      cyc(1);
      chk("restart", {enabled, fault, detect}, 6'h05);
      ctrl_host_model_i.drive(1'b0, 45);
      ctrl_host_model_i.drive(1'b1, 4);
      cyc(1);
      chk("early low", {mode_valid, one_wire}, 6'h00);
      $display("open-led done");
   endtask : t_fault
   always @(posedge i_ref_clk) begin
      n_cycles++;
      if (n_cycles == 20000) begin
         n_mismatch++;
         test_done;
      end
   end
   initial begin
      t_power_reset(12);
      t_pwm;
      t_shutdown;
      t_one_wire;
      t_shutdown;
      t_fault;
      t_power_reset(2);
      test_done;
   end
endmodule : test_led_driver_enable_mode_control

/* hdl/led_driver_enable_mode_control.sv */
// enable, dimming mode detection, soft start and open-led shutdown control
// Notes on behaviour
// R1 - rising control pin in shutdown enables and opens detection window together
// R2 - control pin low longer than 2.5 ms shuts down; switch off
// R3 - mode chosen at every enable; pwm unless detection pattern seen
// R4 - host waits 100 us after enable, then drives low over 260 us
// R5 - qualifying low must finish before 1 ms window from rising edge
// R6 - switch to one-wire mode immediately when pattern completes
// R7 - mode held until shutdown and new enable
// R8 - reference rises to target in 32 steps of 213 us
// R9 - half current limit for first 5 ms, then full limit
// R10 - overvoltage with feedback under half for 8 cycles shuts down
// R11 - after open-led fault, stay off until control pin toggled
// R12 - 600 kHz switching clock; open-led checked once per cycle
// R13 - stored brightness defaults to full scale, restored by power reset
// R14 - pwm mode chops reference at control pin duty cycle
// R15 - control pin synchronised; all intervals timed by internal counters
`timescale 1ns/1ps
`include "led_ctrl_defines.svh"
module led_driver_enable_mode_control
   import led_ctrl_pkg::*;
#(
   parameter cnt_t SHDN_CYC = cnt_t'(`SHDN_CYC),
   parameter cnt_t DET_LOW_CYC = cnt_t'(`DET_LOW_CYC),
   parameter cnt_t WIN_CYC = cnt_t'(`WIN_CYC),
   parameter cnt_t STEP_CYC = cnt_t'(`STEP_CYC),
   parameter cnt_t HALF_CYC = cnt_t'(`HALF_CYC)
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_ctrl_pin,
   input wire logic i_switch_node_ovp,
   input wire logic i_feedback_node_low,
   input wire logic i_bright_load,
   input wire logic [`STEP_W-1:0] i_bright_code,
   output logic o_enabled,
   output logic o_switch_en,
   output logic o_detect_active,
   output logic o_mode_valid,
   output logic o_one_wire_mode,
   output logic [`RAMP_W-1:0] o_ramp_level,
   output logic o_ramp_done,
   output logic o_half_ilim,
   output logic [`STEP_W-1:0] o_ref_code,
   output logic o_ref_chop,
   output logic o_sw_tick,
   output logic o_open_led_fault
);
   localparam cnt_t DELAY_CYC = cnt_t'(`DELAY_CYC);
   localparam cnt_t CNT_MAX = {`CNT_W{1'b1}};
   localparam logic [`SW_DIV_W-1:0] SW_LAST = `SW_DIV_W'(`SW_DIV - 1);
   localparam logic [`OL_W-1:0] OL_LAST = `OL_CYCLES - 4'h1;

   // saturating increment for the low-time and window counters
   function automatic cnt_t sat_inc(input cnt_t v);
      if (v == CNT_MAX) begin
         sat_inc = v;
      end else begin
         sat_inc = v + cnt_t'(1);
      end
   endfunction : sat_inc

   // control pin synchroniser and edge history
   logic ctrl_meta_reg;
   logic ctrl_sync_reg;
   logic ctrl_last_reg;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_meta_reg <= 1'b0;
         ctrl_sync_reg <= 1'b0;
         ctrl_last_reg <= 1'b0;
      end else begin
         ctrl_meta_reg <= i_ctrl_pin; // see R15
         ctrl_sync_reg <= ctrl_meta_reg;
         ctrl_last_reg <= ctrl_sync_reg;
      end
   end

   wire ctrl_rise = ctrl_sync_reg & ~ctrl_last_reg;
   wire ctrl_fall = ~ctrl_sync_reg & ctrl_last_reg;
   // state
   ctl_state_e state_reg;
   ctl_state_e state_next;

   wire st_off = (state_reg == ST_OFF);
   wire st_detect = (state_reg == ST_DETECT);
   wire st_run = (state_reg == ST_RUN);
   wire st_on = ~st_off;
   // enable event opens the detection window in the same cycle
   wire enable_evt = st_off & ctrl_rise; // see R1 see R11

   // low-time counter, cleared whenever the pin is high
   cnt_t low_cnt_reg;
   cnt_t low_cnt_next;

   assign low_cnt_next = ctrl_sync_reg ? '0 : sat_inc(low_cnt_reg);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         low_cnt_reg <= '0;
      end else begin
         low_cnt_reg <= low_cnt_next;
      end
   end

   wire shdn_hit = st_on & (low_cnt_reg >= SHDN_CYC); // see R2

   // detection window counter
   cnt_t win_cnt_reg;
   cnt_t win_cnt_next;

   assign win_cnt_next = enable_evt ? '0 :
                         st_detect ? sat_inc(win_cnt_reg) : win_cnt_reg;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         win_cnt_reg <= '0;
      end else begin
         win_cnt_reg <= win_cnt_next; // see R15
      end
   end

   // window timed from the enabling rising edge
   wire win_end = st_detect & (win_cnt_reg >= WIN_CYC - cnt_t'(1)); // see R5
   wire delay_done = win_cnt_reg >= DELAY_CYC; // see R4

   // a low period qualifies only if it began after the delay
   logic low_ok_reg;
   logic low_ok_next;

   assign low_ok_next = ctrl_sync_reg ? 1'b0 :
                        (ctrl_fall & st_detect & delay_done) ? 1'b1 :
                        low_ok_reg;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         low_ok_reg <= 1'b0;
      end else begin
         low_ok_reg <= low_ok_next; // see R4
      end
   end

   // pattern complete: qualified low held more than the detect time
   wire det_hit = st_detect & low_ok_reg & (low_cnt_reg > DET_LOW_CYC); // see R4 see R5

   // open-led checking on the switching clock
   logic [`SW_DIV_W-1:0] sw_div_reg;
   logic [`SW_DIV_W-1:0] sw_div_next;
   logic sw_tick_reg;

   wire sw_wrap = (sw_div_reg == SW_LAST);

   assign sw_div_next = sw_wrap ? '0 : sw_div_reg + `SW_DIV_W'(1);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sw_div_reg <= '0;
         sw_tick_reg <= 1'b0;
      end else begin
         sw_div_reg <= sw_div_next; // see R12
         sw_tick_reg <= sw_wrap;
      end
   end

   logic [`OL_W-1:0] ol_cnt_reg;
   logic [`OL_W-1:0] ol_cnt_next;

   wire ol_cond = i_switch_node_ovp & i_feedback_node_low;
   wire ol_trip = st_on & sw_tick_reg & ol_cond & (ol_cnt_reg == OL_LAST); // see R10

   assign ol_cnt_next = st_off ? '0 :
                        ~sw_tick_reg ? ol_cnt_reg :
                        ol_cond ? ol_cnt_reg + `OL_W'(1) : '0; // see R12

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ol_cnt_reg <= '0;
      end else begin
         ol_cnt_reg <= ol_cnt_next;
      end
   end

   // fault stays latched until the next enable
   logic fault_reg;
   logic fault_next;

   assign fault_next = ol_trip ? 1'b1 : enable_evt ? 1'b0 : fault_reg; // see R11

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
      end
   end

   // state transitions
   wire go_off = shdn_hit | ol_trip; // see R2 see R10

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (ctrl_rise) begin
               state_next = ST_DETECT; // see R1
            end
         end
         ST_DETECT: begin
            if (go_off) begin
               state_next = ST_OFF;
            end else if (det_hit | win_end) begin
               state_next = ST_RUN; // see R6
            end
         end
         ST_RUN: begin
            if (go_off) begin
               state_next = ST_OFF;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // dimming mode, cleared to pwm at each enable
   logic mode_reg;
   logic mode_next;

   assign mode_next = enable_evt ? 1'b0 :
                      (det_hit & ~go_off) ? 1'b1 : mode_reg; // see R3 see R6 see R7

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // stored brightness step, full scale after power reset
   step_t bright_reg;
   step_t bright_next;

   wire bright_wr = i_bright_load & st_run & mode_reg;

   assign bright_next = bright_wr ? i_bright_code : bright_reg;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bright_reg <= `FULL_STEP; // see R13
      end else begin
         bright_reg <= bright_next;
      end
   end

   // soft-start ramp of the reference
   ramp_t ramp_reg;
   ramp_t ramp_next;
   cnt_t step_cnt_reg;
   cnt_t step_cnt_next;

   wire ramp_done = (ramp_reg == `RAMP_STEPS);
   wire step_end = st_on & ~ramp_done & (step_cnt_reg == STEP_CYC - cnt_t'(1));

   assign step_cnt_next = (enable_evt | step_end) ? '0 :
                          (st_on & ~ramp_done) ? step_cnt_reg + cnt_t'(1) : step_cnt_reg;
   assign ramp_next = enable_evt ? '0 :
                      step_end ? ramp_reg + ramp_t'(1) : ramp_reg; // see R8

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ramp_reg <= '0;
         step_cnt_reg <= '0;
      end else begin
         ramp_reg <= ramp_next;
         step_cnt_reg <= step_cnt_next;
      end
   end

   // half current limit window after enable
   logic half_reg;
   logic half_next;
   cnt_t half_cnt_reg;
   cnt_t half_cnt_next;

   wire half_end = half_reg & (half_cnt_reg == HALF_CYC - cnt_t'(1));

   assign half_cnt_next = enable_evt ? '0 :
                          half_reg ? half_cnt_reg + cnt_t'(1) : half_cnt_reg;
   assign half_next = enable_evt ? 1'b1 : half_end ? 1'b0 : half_reg; // see R9

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         half_reg <= 1'b0;
         half_cnt_reg <= '0;
      end else begin
         half_reg <= half_next;
         half_cnt_reg <= half_cnt_next;
      end
   end

   // chopped reference in pwm mode, steady in one-wire mode
   logic chop_reg;
   logic chop_next;

   assign chop_next = st_run & ~go_off & (mode_reg | ctrl_sync_reg); // see R14 see R2

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         chop_reg <= 1'b0;
      end else begin
         chop_reg <= chop_next;
      end
   end

   // outputs
   assign o_enabled = st_on;
   assign o_switch_en = st_on; // see R2 see R10
   assign o_detect_active = st_detect;
   assign o_mode_valid = st_run;
   assign o_one_wire_mode = mode_reg;
   assign o_ramp_level = ramp_reg;
   assign o_ramp_done = ramp_done;
   assign o_half_ilim = half_reg & st_on;
   assign o_ref_code = bright_reg;
   assign o_ref_chop = chop_reg;
   assign o_sw_tick = sw_tick_reg;
   assign o_open_led_fault = fault_reg;
endmodule : led_driver_enable_mode_control
